// File: common/dmabmc_pkg.sv
// Shared constants and types for the DMA bus-mode and poll-demand control block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data on a single clock.
//
// Summary of operation
// - Bit 7 selects buffer byte order, descriptors unchanged.
// - Bits 6..2 give the dword gap between descriptors.
// - Bit 1 low favours receive, high favours transmit.
// - Soft reset clears internals, keeps configuration registers.
// - Soft reset bit self-clears when the sequence ends.
// - Transmit poll write while suspended fetches, checks ownership.
// - Receive poll write while suspended fetches, checks ownership.
// - Receive list base in bits 31..2, low bits 00.
package dmabmc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_BUS_MODE = 8'h00;
  localparam logic [7:0] OFS_TX_POLL = 8'h08;
  localparam logic [7:0] OFS_RX_POLL = 8'h10;
  localparam logic [7:0] OFS_RX_BASE = 8'h18;

  // Bus-mode field positions.
  localparam int BIT_BYTE_ORDER = 7;
  localparam int GAP_MSB = 6;
  localparam int GAP_LSB = 2;
  localparam int BIT_ARB = 1;
  localparam int BIT_SOFT_RST = 0;
  localparam int GAP_W = GAP_MSB - GAP_LSB + 1;

  // Reset values.
  localparam logic [31:0] POLL_RESET = 32'h0FFFFFFF;
  localparam logic [31:0] BASE_RESET = 32'h00000000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] ALIGN_BITS = 2'h0;

  // Timing and geometry.
  localparam int SRST_CYCLES = 16;
  localparam int DESC_BYTES = 16;

  typedef enum logic {POLL_IDLE, POLL_FETCH} dmabmc_poll_e;
  typedef enum logic [1:0] {ARB_IDLE, ARB_TX, ARB_RX} dmabmc_arb_e;

endpackage

// File: verilog/dmabmc_poll.sv
// Poll-demand engine for one direction: fetch and ownership test of a descriptor.
// Assumes the descriptor fetcher answers each request with a one-cycle done pulse.
`timescale 1ns/1ns
module dmabmc_poll (
  // Clock and resets.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_srst,
  // Process state and demand.
  input wire logic i_suspended,
  input wire logic i_demand,
  // Descriptor fetcher.
  input wire logic i_fetch_done,
  input wire logic i_own,
  output logic o_fetch_req,
  output logic o_start
);

  typedef struct packed {
    dmabmc_pkg::dmabmc_poll_e st;
    logic fetch;
    logic start;
  } dmabmc_poll_s;

  localparam dmabmc_poll_s RST_S = '{dmabmc_pkg::POLL_IDLE, 1'b0, 1'b0};

  dmabmc_poll_s q;
  dmabmc_poll_s d;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.start = 1'b0;
    unique case (q.st)
      dmabmc_pkg::POLL_IDLE: begin
        // A demand outside suspension is dropped, so it cannot disturb a live list.
        if (i_demand && i_suspended) begin
          d.st = dmabmc_pkg::POLL_FETCH;
          d.fetch = 1'b1;
        end
      end
      dmabmc_pkg::POLL_FETCH: begin
        if (i_fetch_done) begin
          d.st = dmabmc_pkg::POLL_IDLE;
          d.fetch = 1'b0;
          d.start = i_own;
        end
      end
    endcase
    if (i_srst) begin
      d = RST_S;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  assign o_fetch_req = q.fetch;
  assign o_start = q.start;

endmodule

// File: verilog/dmabmc_arb.sv
// Two-way bus arbiter between transmit and receive DMA with a priority select.
// Assumes a requester holds its request until granted and pulses done at release.
`timescale 1ns/1ns
module dmabmc_arb (
  // Clock and resets.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_srst,
  // Requests.
  input wire logic i_tx_first,
  input wire logic i_tx_req,
  input wire logic i_rx_req,
  input wire logic i_done,
  // Grants.
  output logic o_tx_gnt,
  output logic o_rx_gnt
);

  typedef struct packed {
    dmabmc_pkg::dmabmc_arb_e st;
    logic tx_gnt;
    logic rx_gnt;
  } dmabmc_arb_s;

  localparam dmabmc_arb_s RST_S = '{dmabmc_pkg::ARB_IDLE, 1'b0, 1'b0};

  dmabmc_arb_s q;
  dmabmc_arb_s d;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    unique case (q.st)
      dmabmc_pkg::ARB_IDLE: begin
        // Priority only matters on a tie; a held grant is never pre-empted.
        if (i_tx_req && (i_tx_first || !i_rx_req)) begin
          d.st = dmabmc_pkg::ARB_TX;
          d.tx_gnt = 1'b1;
        end else if (i_rx_req) begin
          d.st = dmabmc_pkg::ARB_RX;
          d.rx_gnt = 1'b1;
        end
      end
      dmabmc_pkg::ARB_TX, dmabmc_pkg::ARB_RX: begin
        if (i_done) begin
          d = RST_S;
        end
      end
      default: begin
        d = RST_S;
      end
    endcase
    if (i_srst) begin
      d = RST_S;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  assign o_tx_gnt = q.tx_gnt;
  assign o_rx_gnt = q.rx_gnt;

endmodule

// File: verilog/dmabmc_top.sv
// Bus-mode, poll-demand and receive list base registers of the DMA engine.
// Assumes a byte-addressed Avalon-MM master and descriptor and data movers outside.
`timescale 1ns/1ns
module dmabmc_top #(
  parameter int SRST_CYCLES = dmabmc_pkg::SRST_CYCLES,
  parameter int DESC_BYTES = dmabmc_pkg::DESC_BYTES
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Avalon-MM slave.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Process state from the DMA engines.
  input wire logic i_tx_suspended,
  input wire logic i_rx_suspended,
  // Descriptor fetchers.
  input wire logic i_tx_fetch_done,
  input wire logic i_tx_own,
  input wire logic i_rx_fetch_done,
  input wire logic i_rx_own,
  output logic o_tx_fetch_req,
  output logic o_tx_start,
  output logic o_rx_fetch_req,
  output logic o_rx_start,
  // Receive descriptor walk.
  input wire logic i_rx_desc_advance,
  output logic [31:0] o_rx_desc_addr,
  // Bus arbitration.
  input wire logic i_tx_bus_req,
  input wire logic i_rx_bus_req,
  input wire logic i_bus_done,
  output logic o_tx_bus_gnt,
  output logic o_rx_bus_gnt,
  // Data path toward host memory.
  input wire logic [31:0] i_buf_data,
  input wire logic i_buf_is_desc,
  output logic [31:0] o_bus_data,
  // Configuration and internal reset.
  output logic o_big_endian,
  output logic [dmabmc_pkg::GAP_W-1:0] o_desc_gap,
  output logic o_tx_priority,
  output logic o_int_rst
);

  localparam int CNT_W = $clog2(SRST_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SRST_CYCLES - 1);
  localparam logic [31:0] DESC_STEP = 32'(DESC_BYTES);

  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    logic [7:1] mode;
    logic srst_busy;
    logic [CNT_W-1:0] srst_cnt;
    logic [31:0] tx_poll;
    logic [31:0] rx_poll;
    logic [31:2] rx_base;
    logic [31:0] desc_addr;
    logic tx_dem;
    logic rx_dem;
    logic [31:0] bus_data;
  } dmabmc_top_s;

  localparam dmabmc_top_s RST_S = '{
    wait_n: 1'b0,
    rdata: 32'h00000000,
    mode: dmabmc_pkg::MODE_RESET[7:1],
    srst_busy: dmabmc_pkg::MODE_RESET[dmabmc_pkg::BIT_SOFT_RST],
    srst_cnt: '0,
    tx_poll: dmabmc_pkg::POLL_RESET,
    rx_poll: dmabmc_pkg::POLL_RESET,
    rx_base: dmabmc_pkg::BASE_RESET[31:2],
    desc_addr: dmabmc_pkg::BASE_RESET,
    tx_dem: 1'b0,
    rx_dem: 1'b0,
    bus_data: 32'h00000000
  };

  dmabmc_top_s q;
  dmabmc_top_s d;

  logic req;
  logic acc;
  logic wr;
  logic [31:0] rd_mux;
  logic [31:0] base_full;
  logic [31:0] gap_bytes;
  logic [31:0] base_new;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for a partial write.

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and derived values.

  always_comb begin
    base_full = {q.rx_base, dmabmc_pkg::ALIGN_BITS};
    gap_bytes = {25'h0000000, q.mode[dmabmc_pkg::GAP_MSB:dmabmc_pkg::GAP_LSB], 2'h0};
    base_new = merge(base_full, i_avs_writedata, i_avs_byteenable);
    rd_mux = 32'h00000000;
    unique case (i_avs_address)
      dmabmc_pkg::OFS_BUS_MODE: begin
        rd_mux = {24'h000000, q.mode, q.srst_busy};
      end
      dmabmc_pkg::OFS_TX_POLL: begin
        rd_mux = q.tx_poll;
      end
      dmabmc_pkg::OFS_RX_POLL: begin
        rd_mux = q.rx_poll;
      end
      dmabmc_pkg::OFS_RX_BASE: begin
        rd_mux = base_full;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    d = q;
    req = i_avs_read | i_avs_write;
    // The request is answered one cycle after it appears; the write lands on the edge after that.
    acc = req && q.wait_n;
    wr = acc && i_avs_write;
    d.tx_dem = 1'b0;
    d.rx_dem = 1'b0;

    if (req && !q.wait_n) begin
      d.wait_n = 1'b1;
      d.rdata = i_avs_read ? rd_mux : 32'h00000000;
    end else begin
      d.wait_n = 1'b0;
    end

    // Register writes; unmapped offsets are ignored.
    if (wr) begin
      unique case (i_avs_address)
        dmabmc_pkg::OFS_BUS_MODE: begin
          // Bus-mode fields are assumed written with both processes stopped.
          if (i_avs_byteenable[0]) begin
            d.mode = i_avs_writedata[7:1];
            if (i_avs_writedata[dmabmc_pkg::BIT_SOFT_RST] && !q.srst_busy) begin
              d.srst_busy = 1'b1;
              d.srst_cnt = '0;
            end
          end
        end
        dmabmc_pkg::OFS_TX_POLL: begin
          d.tx_poll = merge(q.tx_poll, i_avs_writedata, i_avs_byteenable);
          d.tx_dem = 1'b1;
        end
        dmabmc_pkg::OFS_RX_POLL: begin
          d.rx_poll = merge(q.rx_poll, i_avs_writedata, i_avs_byteenable);
          d.rx_dem = 1'b1;
        end
        dmabmc_pkg::OFS_RX_BASE: begin
          // Loading the walk pointer here relies on receive being stopped.
          d.rx_base = base_new[31:2];
          d.desc_addr = {base_new[31:2], dmabmc_pkg::ALIGN_BITS};
        end
        default: begin
          d.rx_base = q.rx_base;
        end
      endcase
    end

    // Descriptor walk: each step covers one descriptor plus the programmed gap.
    if (i_rx_desc_advance && !q.srst_busy) begin
      d.desc_addr = q.desc_addr + DESC_STEP + gap_bytes;
    end

    // Soft reset sequence; configuration registers keep their contents.
    if (q.srst_busy) begin
      if (q.srst_cnt == CNT_LAST) begin
        d.srst_busy = 1'b0;
        d.srst_cnt = '0;
        d.desc_addr = base_full;
      end else begin
        d.srst_cnt = q.srst_cnt + CNT_W'(1);
      end
      d.tx_dem = 1'b0;
      d.rx_dem = 1'b0;
    end

    // Swapping only data keeps descriptors readable in either mode.
    if (q.mode[dmabmc_pkg::BIT_BYTE_ORDER] && !i_buf_is_desc) begin
      d.bus_data = {i_buf_data[7:0], i_buf_data[15:8], i_buf_data[23:16], i_buf_data[31:24]};
    end else begin
      d.bus_data = i_buf_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Poll engines and arbiter.

  dmabmc_poll u_tx_poll (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_srst(q.srst_busy),
    .i_suspended(i_tx_suspended),
    .i_demand(q.tx_dem),
    .i_fetch_done(i_tx_fetch_done),
    .i_own(i_tx_own),
    .o_fetch_req(o_tx_fetch_req),
    .o_start(o_tx_start)
  );

  dmabmc_poll u_rx_poll (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_srst(q.srst_busy),
    .i_suspended(i_rx_suspended),
    .i_demand(q.rx_dem),
    .i_fetch_done(i_rx_fetch_done),
    .i_own(i_rx_own),
    .o_fetch_req(o_rx_fetch_req),
    .o_start(o_rx_start)
  );

  dmabmc_arb u_arb (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_srst(q.srst_busy),
    .i_tx_first(q.mode[dmabmc_pkg::BIT_ARB]),
    .i_tx_req(i_tx_bus_req),
    .i_rx_req(i_rx_bus_req),
    .i_done(i_bus_done),
    .o_tx_gnt(o_tx_bus_gnt),
    .o_rx_gnt(o_rx_bus_gnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops.

  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = !q.wait_n;
  assign o_rx_desc_addr = q.desc_addr;
  assign o_bus_data = q.bus_data;
  assign o_big_endian = q.mode[dmabmc_pkg::BIT_BYTE_ORDER];
  assign o_desc_gap = q.mode[dmabmc_pkg::GAP_MSB:dmabmc_pkg::GAP_LSB];
  assign o_tx_priority = q.mode[dmabmc_pkg::BIT_ARB];
  assign o_int_rst = q.srst_busy;

endmodule

// File: tb/dmabmc_host_model.sv
// Host memory model: answers descriptor fetch requests with a done pulse and owner bit.
// Assumes the request is held until the done pulse and dropped one cycle later.
`timescale 1ns/1ns
module dmabmc_host_model (
  // Clock, reset and fetch handshake.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_fetch_req,
  input wire logic i_own_bit,
  output logic o_fetch_done,
  output logic o_own
);
  logic [2:0] wait_q;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fetch_done <= 1'b0;
      o_own <= 1'b0;
      wait_q <= 3'h2;
    end else begin
      o_fetch_done <= 1'b0;
      // The owner bit means nothing outside done, so it toggles to expose early sampling.
      o_own <= ~o_own;
      if (i_fetch_req && !o_fetch_done) begin
        if (wait_q == 3'h0) begin
          o_fetch_done <= 1'b1;
          o_own <= i_own_bit;
          wait_q <= 3'($urandom_range(4));
        end else begin
          wait_q <= wait_q - 3'h1;
        end
      end
    end
  end
endmodule

// File: tb/dmabmc_top_props.sv
// Concurrent checks on the ports of the DMA bus-mode and poll control block.
// Assumes one clock domain and the asynchronous reset of the top module.
`timescale 1ns/1ns
module dmabmc_top_props #(
  parameter int SRST_CYCLES = 16,
  parameter int DESC_BYTES = 16
) (
  input wire logic i_sys_clk, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest,
  input wire logic [7:0] i_avs_address,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata, o_avs_readdata, i_buf_data, o_bus_data,
  input wire logic [31:0] o_rx_desc_addr,
  input wire logic i_tx_suspended, i_rx_suspended, i_tx_fetch_done, i_tx_own,
  input wire logic i_rx_fetch_done, i_rx_own, o_tx_fetch_req, o_tx_start, o_rx_fetch_req,
  input wire logic o_rx_start, i_rx_desc_advance, i_tx_bus_req, i_rx_bus_req,
  input wire logic o_tx_bus_gnt, o_rx_bus_gnt, i_buf_is_desc, o_big_endian,
  input wire logic o_tx_priority, o_int_rst,
  input wire logic [dmabmc_pkg::GAP_W-1:0] o_desc_gap
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] hi_q;
  logic [31:0] d_q;
  logic acc;
  assign acc = i_avs_write && !o_avs_waitrequest;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_q <= 8'h00;
      d_q <= 32'h00000000;
    end else begin
      hi_q <= o_int_rst ? hi_q + 8'h01 : 8'h00;
      d_q <= i_buf_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_SWAP: assert property (
    $past(o_big_endian && !i_buf_is_desc && !o_int_rst) && !o_int_rst |->
    o_bus_data == {d_q[7:0], d_q[15:8], d_q[23:16], d_q[31:24]}) else $error("bad swap");
  AST_PASS: assert property (
    $past((!o_big_endian || i_buf_is_desc) && !o_int_rst) && !o_int_rst |->
    o_bus_data == d_q) else $error("bad pass-through");
  AST_GAP: assert property (
    i_rx_desc_advance && !o_int_rst && !(acc && i_avs_address inside {8'h00, 8'h18}) |=>
    o_rx_desc_addr == $past(o_rx_desc_addr) + 32'(DESC_BYTES) + {25'h0, $past(o_desc_gap), 2'h0})
    else $error("bad descriptor step");
  AST_ARB: assert property (
    !o_tx_bus_gnt && !o_rx_bus_gnt && i_tx_bus_req && i_rx_bus_req && !o_int_rst |=>
    o_tx_bus_gnt == $past(o_tx_priority) && o_rx_bus_gnt != $past(o_tx_priority))
    else $error("bad grant");
  AST_SRST_RISE: assert property (
    acc && i_avs_address == 8'h00 && i_avs_byteenable[0] && i_avs_writedata[0] && !o_int_rst
    |=> o_int_rst) else $error("soft reset missing");
  AST_SRST_IDLE: assert property (
    $past(o_int_rst) && o_int_rst |->
    !(o_tx_fetch_req || o_rx_fetch_req || o_tx_bus_gnt || o_rx_bus_gnt))
    else $error("activity in soft reset");
  AST_SRST_LEN: assert property (
    $fell(o_int_rst) |-> hi_q == 8'(SRST_CYCLES)) else $error("bad soft reset length");
  AST_SRST_MAX: assert property (
    o_int_rst |-> hi_q < 8'(SRST_CYCLES)) else $error("soft reset too long");
  AST_TX_POLL: assert property (
    acc && i_avs_address == 8'h08 && !o_tx_fetch_req && !o_int_rst ##1
    i_tx_suspended && !o_int_rst |=> o_tx_fetch_req) else $error("no tx fetch");
  AST_TX_START: assert property (
    o_tx_fetch_req && i_tx_fetch_done && !o_int_rst |=>
    !o_tx_fetch_req && o_tx_start == $past(i_tx_own)) else $error("bad tx start");
  AST_RX_POLL: assert property (
    acc && i_avs_address == 8'h10 && !o_rx_fetch_req && !o_int_rst ##1
    i_rx_suspended && !o_int_rst |=> o_rx_fetch_req) else $error("no rx fetch");
  AST_RX_START: assert property (
    o_rx_fetch_req && i_rx_fetch_done && !o_int_rst |=>
    !o_rx_fetch_req && o_rx_start == $past(i_rx_own)) else $error("bad rx start");
  AST_BASE: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h18 |->
    o_avs_readdata[1:0] == 2'h0) else $error("base not aligned");
  cover property (o_tx_start);
  cover property (o_rx_start);
  cover property ($fell(o_int_rst));
  cover property (o_tx_bus_gnt && o_tx_priority);
endmodule
bind dmabmc_top dmabmc_top_props #(.SRST_CYCLES(SRST_CYCLES), .DESC_BYTES(DESC_BYTES)) u_props (.*);

// File: tb/tb_dmabmc_top.sv
// Self-checking bench for the DMA bus-mode, poll-demand and receive base registers.
// Assumes the host memory model and the bound checker beside the design.
`timescale 1ns/1ns
module tb_dmabmc_top;
  localparam int SRST = 4;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, i_buf_data = 32'h0, q, v, base, addr;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic i_tx_suspended = 1'b0, i_rx_suspended = 1'b0, i_rx_desc_advance = 1'b0;
  logic i_tx_bus_req = 1'b0, i_rx_bus_req = 1'b0, i_bus_done = 1'b0, i_buf_is_desc = 1'b0;
  logic tx_own_bit = 1'b0, rx_own_bit = 1'b0, i_tx_fetch_done, i_tx_own, i_rx_fetch_done;
  logic i_rx_own, o_avs_waitrequest, o_tx_fetch_req, o_tx_start, o_rx_fetch_req, o_rx_start;
  logic o_tx_bus_gnt, o_rx_bus_gnt, o_big_endian, o_tx_priority, o_int_rst;
  logic [31:0] o_avs_readdata, o_rx_desc_addr, o_bus_data;
  logic [dmabmc_pkg::GAP_W-1:0] o_desc_gap;
  int err_count = 0, samples_checked = 0, n;
  dmabmc_top #(.SRST_CYCLES(SRST)) uut (.*);
  dmabmc_host_model u_txm (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fetch_req(o_tx_fetch_req),
    .i_own_bit(tx_own_bit), .o_fetch_done(i_tx_fetch_done), .o_own(i_tx_own));
  dmabmc_host_model u_rxm (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_fetch_req(o_rx_fetch_req),
    .i_own_bit(rx_own_bit), .o_fetch_done(i_rx_fetch_done), .o_own(i_rx_own));
  initial forever #2 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int c);
    repeat (c) @(posedge i_sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    // The slave answers one cycle after the request; only the watchdog ends a hang.
    do begin
      tk(1);
      c++;
    end while (o_avs_waitrequest !== 1'b0);
    chk(32'(c), 32'h2);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    tk(1);
  endtask
  function automatic logic [31:0] swp(input logic [31:0] x, input logic on);
    return on ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
  endfunction
  task automatic poll(input logic rx, input logic own, input logic susp);
    logic [7:0] a;
    a = rx ? 8'h10 : 8'h08;
    v = $urandom;
    i_tx_suspended <= susp & !rx;
    i_rx_suspended <= susp & rx;
    tx_own_bit <= own;
    rx_own_bit <= own;
    bus(1'b1, a, v);
    n = 0;
    while ((rx ? o_rx_start : o_tx_start) !== 1'b1 && n < 12) begin
      tk(1);
      n++;
    end
    chk({31'h0, n < 12}, {31'h0, own & susp});
    i_tx_suspended <= 1'b0;
    i_rx_suspended <= 1'b0;
    tk(3);
    bus(1'b0, a, 32'h0);
    chk(q, v);
  endtask
  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(74076));
    tk(20);
    i_rst <= 1'b0;
    tk(1);
    // Reset values, with one unmapped place at the end.
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(i * 8), 32'h0);
      chk(q, (i == 1 || i == 2) ? 32'h0FFFFFFF : 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      v = {24'h0, i[1], 5'($urandom), i[0], 1'b0};
      bus(1'b1, 8'h00, v);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, v);
      chk({24'h0, o_big_endian, o_desc_gap, o_tx_priority, 1'b0}, v);
      repeat (8) begin
        i_buf_data <= $urandom;
        i_buf_is_desc <= 1'($urandom);
        tk(2);
        chk(o_bus_data, swp(i_buf_data, v[7] & !i_buf_is_desc));
      end
      base = $urandom;
      bus(1'b1, 8'h18, base);
      bus(1'b0, 8'h18, 32'h0);
      addr = base & 32'hFFFFFFFC;
      chk(q, addr);
      chk(o_rx_desc_addr, addr);
      repeat (3) begin
        i_rx_desc_advance <= 1'b1;
        tk(1);
        i_rx_desc_advance <= 1'b0;
        tk(1);
        addr += 16 + 4 * v[6:2];
        chk(o_rx_desc_addr, addr);
      end
      // Both sides ask at once; the loser keeps asking until it is served.
      i_tx_bus_req <= 1'b1;
      i_rx_bus_req <= 1'b1;
      tk(2);
      chk({30'h0, o_tx_bus_gnt, o_rx_bus_gnt}, {30'h0, v[1], !v[1]});
      for (int k = 0; k < 2; k++) begin
        i_bus_done <= 1'b1;
        i_tx_bus_req <= !v[1] && k == 0;
        i_rx_bus_req <= v[1] && k == 0;
        tk(1);
        i_bus_done <= 1'b0;
        tk(4);
        chk({30'h0, o_tx_bus_gnt, o_rx_bus_gnt},
            {30'h0, !v[1] && k == 0, v[1] && k == 0});
      end
    end
    bus(1'b1, 8'h00, v | 32'h1);
    n = 0;
    while (o_int_rst === 1'b1 && n < 40) begin
      tk(1);
      n++;
    end
    chk(32'(n), 32'(SRST));
    bus(1'b0, 8'h00, 32'h0);
    chk(q, v);
    chk(o_rx_desc_addr, base & 32'hFFFFFFFC);
    // With lane 0 disabled the bus-mode word, soft reset bit included, must stay put.
    i_avs_byteenable <= 4'hE;
    bus(1'b1, 8'h00, 32'h000000FF);
    i_avs_byteenable <= 4'hF;
    bus(1'b0, 8'h00, 32'h0);
    chk(q, v);
    chk({31'h0, o_int_rst}, 32'h0);
    // Receive demands are only made while receive is suspended.
    for (int i = 0; i < 8; i++) poll(i[0], i[1], i[2] | i[0]);
    final_report();
  end
endmodule
